// *** bench/pcc_chk.sv ***
// port assertions for the partition configuration command block
`timescale 1ns/1ns
`default_nettype none
module pcc_chk #(
   parameter bit TOP_PARAM = 1'b0
) (
   input wire logic                  mclk,
   input wire logic                  rst_b,
   input wire pcc_pkg::pcc_strobes_t strobes_n,
   input wire logic                  dq_oe_b,
   input wire logic [15:0]           partition_layout_config,
   input wire logic [7:0]            plane_partition,
   input wire logic [2:0]            partition_count,
   input wire logic                  dual_work_ok
);
   import pcc_pkg::*;
   logic [3:0] we_hi_ff;
   logic [3:0] nxt_we_hi;
   logic [2:0] sel;
   logic [1:0] p0, p1, p2, p3;
   assign sel = partition_layout_config[10:8];
   assign {p3, p2, p1, p0} = plane_partition;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // cycles since the write strobe was last seen low
   always_comb begin
      nxt_we_hi = we_hi_ff;
      if (strobes_n.we_n == 1'b0) nxt_we_hi = 4'h0;
      else if (we_hi_ff != 4'hF) nxt_we_hi = we_hi_ff + 4'h1;
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) we_hi_ff <= 4'hF;
      else we_hi_ff <= nxt_we_hi;
   end
   rsvd_bits_zero_a: assert property (
      partition_layout_config[15:11] == 5'h00 && partition_layout_config[7:0] == 8'h00)
      else $error("reserved bits set");
   cfg_after_write_a: assert property (
      $changed(partition_layout_config) |-> we_hi_ff >= 4'h1 && we_hi_ff <= 4'h6)
      else $error("config changed without a write end");
   cfg_reset_val_a: assert property ($rose(rst_b) |-> sel == (TOP_PARAM ? PSEL_RST_TOP : PSEL_RST_BOTTOM))
      else $error("wrong reset selection");
   one_part_a: assert property (
      sel == 3'h0 |-> partition_count == 3'h1 && !dual_work_ok && p0 == p1 && p1 == p2 && p2 == p3)
      else $error("single partition wrong");
   two_low_a: assert property (sel == 3'h1 |-> partition_count == 3'h2 && p0 != p1 && p1 == p2 && p2 == p3)
      else $error("split after plane 0 wrong");
   two_half_a: assert property (sel == 3'h2 |-> partition_count == 3'h2 && p0 == p1 && p1 != p2 && p2 == p3)
      else $error("half split wrong");
   two_high_a: assert property (sel == 3'h4 |-> partition_count == 3'h2 && p0 == p1 && p1 == p2 && p2 != p3)
      else $error("split before plane 3 wrong");
   three_part_a: assert property (
      sel inside {3'h3, 3'h5, 3'h6} |-> partition_count == 3'h3 && dual_work_ok && p0 != p3
         && (sel != 3'h3 || p2 == p3) && (sel != 3'h6 || p0 == p1) && (sel != 3'h5 || p1 == p2))
      else $error("three partition layout wrong");
   four_part_a: assert property (
      sel == 3'h7 |-> partition_count == 3'h4 && dual_work_ok
         && p0 != p1 && p1 != p2 && p2 != p3 && p0 != p3 && p0 != p2 && p1 != p3)
      else $error("four partition layout wrong");
   drive_on_read_a: assert property (!dq_oe_b |-> !$past(strobes_n.oe_n, 3) && !$past(strobes_n.ce_n, 3))
      else $error("data driven without a read");
endmodule
bind pcc_cmd pcc_chk #(.TOP_PARAM(TOP_PARAM)) u_pcc_chk (
   .mclk(mclk), .rst_b(rst_b), .strobes_n(strobes_n), .dq_oe_b(dq_oe_b),
   .partition_layout_config(partition_layout_config), .plane_partition(plane_partition),
   .partition_count(partition_count), .dual_work_ok(dual_work_ok));
`default_nettype wire

// *** bench/pcc_host.sv ***
// host bus master model driving the device pins
`timescale 1ns/1ns
`default_nettype none
module pcc_host (
   input  wire logic              mclk,
   input  wire logic [15:0]       dq_out,
   output var pcc_pkg::pcc_strobes_t strobes_n,
   output var pcc_pkg::pcc_bus_t     bus_in
);
   import pcc_pkg::*;
   initial begin
      strobes_n = '1;
      bus_in    = '0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // address is scrambled after adv rises, so only the adv edge may latch it
   task automatic wr(input logic [1:0] pl, input logic [15:0] a, input logic [7:0] c);
      cyc(3);
      bus_in    = '{plane: pl, addr: a, data: {8'h00, c}};
      strobes_n = 4'b0001;
      cyc(4);
      strobes_n.adv_n = 1'b1;
      cyc(4);
      bus_in.addr = ~a;
      cyc(4);
      // data must outlast the strobe edge on which the device takes it
      strobes_n   = '1;
      cyc(4);
      bus_in.data = ~bus_in.data;
   endtask
   task automatic rd(input logic [1:0] pl, input logic [15:0] a, output logic [15:0] d);
      cyc(3);
      bus_in.plane = pl;
      bus_in.addr  = a;
      strobes_n    = 4'b0010;
      cyc(5);
      d         = dq_out;
      strobes_n = '1;
   endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// self-checking testbench for the partition configuration command block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import pcc_pkg::*;
   localparam logic [15:0] ARR = 16'hA5C3;
   localparam logic [2:0]  CNT [8] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4};
   logic         mclk;
   logic         rst_b;
   pcc_strobes_t strobes_n;
   pcc_bus_t     bus_in;
   logic [3:0]   plane_busy;
   logic [15:0]  dq_out, partition_layout_config, rdat;
   logic [7:0]   plane_partition;
   logic [2:0]   partition_count;
   logic         dq_oe_b, dual_work_ok, read_blocked;
   int           mismatches, checks_done;
   pcc_cmd #(.TOP_PARAM(1'b0)) u_pcc_cmd (
      .mclk(mclk), .rst_b(rst_b), .strobes_n(strobes_n), .bus_in(bus_in), .array_data(ARR),
      .plane_busy(plane_busy), .dq_out(dq_out), .dq_oe_b(dq_oe_b),
      .partition_layout_config(partition_layout_config), .plane_partition(plane_partition),
      .partition_count(partition_count), .dual_work_ok(dual_work_ok), .read_blocked(read_blocked));
   pcc_host u_pcc_host (.mclk(mclk), .dq_out(dq_out), .strobes_n(strobes_n), .bus_in(bus_in));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // setup then confirm; x flips confirm address bits
   task automatic cfg(input logic [2:0] s, input logic [7:0] c2, input logic [15:0] x);
      u_pcc_host.wr(2'h0, {5'h1F, s, 8'hFF}, CMD_CFG_SETUP);
      u_pcc_host.wr(2'h0, {5'h1F, s, 8'hFF} ^ x, c2);
   endtask
   task automatic rd_id();
      u_pcc_host.wr(2'h0, 16'h0000, CMD_READ_ID);
      u_pcc_host.rd(2'h0, ID_ADDR_PART_CFG, rdat);
   endtask
   task automatic rd_stat(input logic [15:0] exp);
      u_pcc_host.wr(2'h0, 16'h0000, CMD_READ_STATUS);
      u_pcc_host.rd(2'h0, 16'h0000, rdat);
      chk(rdat & 16'h00B0, exp);
   endtask
   initial begin
      #200000;
      mismatches++;
      finish_test();
   end
   initial begin
      rst_b      = 1'b0;
      plane_busy = 4'h0;
      repeat (20) @(posedge mclk);
      #1 rst_b = 1'b1;
      rd_id();
      chk(rdat, 16'h0100);
      chk({15'h0000, dq_oe_b}, 16'h0000);
      u_pcc_host.rd(2'h0, 16'h0005, rdat);
      chk(rdat, 16'h0000);
      for (int s = 0; s < 8; s++) begin
         cfg(s[2:0], CMD_PART_CONFIRM, 16'h0000);
         chk(partition_layout_config, {5'h00, s[2:0], 8'h00});
         chk({13'h0000, partition_count}, {13'h0000, CNT[s]});
         u_pcc_host.rd(2'h0, 16'h0010, rdat);
         chk(rdat, ARR);
         rd_id();
         chk(rdat, {5'h00, s[2:0], 8'h00});
      end
      cfg(3'h2, 8'h05, 16'h0000);
      chk(partition_layout_config, 16'h0700);
      u_pcc_host.rd(2'h0, 16'h0000, rdat);
      chk(rdat & 16'h00B0, 16'h00B0);
      cfg(3'h2, CMD_PART_CONFIRM, 16'h0000);
      rd_stat(16'h0080);
      cfg(3'h7, CMD_PART_CONFIRM, 16'h0100);
      chk(partition_layout_config, 16'h0200);
      rd_stat(16'h00B0);
      u_pcc_host.wr(2'h0, 16'h0000, CMD_CLEAR_STATUS);
      rd_stat(16'h0080);
      plane_busy = 4'h2;
      u_pcc_host.rd(2'h0, 16'h0000, rdat);
      chk({15'h0000, read_blocked}, 16'h0001);
      chk(rdat & 16'h00B0, 16'h0000);
      u_pcc_host.rd(2'h2, 16'h0000, rdat);
      chk({15'h0000, read_blocked}, 16'h0000);
      chk(rdat & 16'h00B0, 16'h0080);
      u_pcc_host.wr(2'h0, 16'h0000, CMD_READ_ARRAY);
      u_pcc_host.rd(2'h0, 16'h0000, rdat);
      chk(rdat, ARR);
      // volatile register: a mid-run reset brings back the default layout
      rst_b = 1'b0;
      repeat (5) @(posedge mclk);
      #1 rst_b = 1'b1;
      chk(partition_layout_config, 16'h0100);
      rd_id();
      chk(rdat, 16'h0100);
      finish_test();
   end
endmodule
`default_nettype wire

// *** logic/pcc_cmd.sv ***
// command interpreter for the partition layout configuration register
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module pcc_cmd #(
   parameter bit TOP_PARAM = 1'b0
) (
   input  wire logic                 mclk,
   input  wire logic                 rst_b,
   input  wire pcc_pkg::pcc_strobes_t strobes_n,
   input  wire pcc_pkg::pcc_bus_t    bus_in,
   input  wire logic [15:0]          array_data,
   input  wire logic [3:0]           plane_busy,
   output logic [15:0]               dq_out,
   output logic                      dq_oe_b,
   output logic [15:0]               partition_layout_config,
   output logic [7:0]                plane_partition,
   output logic [2:0]                partition_count,
   output logic                      dual_work_ok,
   output logic                      read_blocked
);
   import pcc_pkg::*;

   localparam logic [2:0] PSEL_RST = TOP_PARAM ? PSEL_RST_TOP : PSEL_RST_BOTTOM;
   localparam int         SW       = $bits(pcc_strobes_t) + $bits(pcc_bus_t);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [SW-1:0] sync1_ff;
   logic [SW-1:0] sync2_ff;
   pcc_strobes_t  stb_prev_ff;
   pcc_strobes_t  stb;
   pcc_bus_t      pin;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_ff    <= {SW{1'b1}};
         sync2_ff    <= {SW{1'b1}};
         stb_prev_ff <= '1;
      end else begin
         sync1_ff    <= {strobes_n, bus_in};
         sync2_ff    <= sync1_ff;
         stb_prev_ff <= stb;
      end
   end

   // address and data ride the same flops as the strobes, so each sample is coherent
   assign stb = pcc_strobes_t'(sync2_ff[SW-1 -: $bits(pcc_strobes_t)]);
   assign pin = pcc_bus_t'(sync2_ff[$bits(pcc_bus_t)-1:0]);

   // ---------------------------------------------------------------
   // bus cycle decode
   // ---------------------------------------------------------------
   logic adv_rise;
   logic we_rise;
   logic ce_rise;
   logic write_end;
   logic read_act;

   // a strobe rises when its synchronised level goes from low to high
   function automatic logic rise_of(input logic prev_n, input logic now_n);
      rise_of = now_n & ~prev_n;
   endfunction

   always_comb begin
      adv_rise  = rise_of(stb_prev_ff.adv_n, stb.adv_n) & ~stb.ce_n;
      we_rise   = rise_of(stb_prev_ff.we_n, stb.we_n);
      ce_rise   = rise_of(stb_prev_ff.ce_n, stb.ce_n);
      // write ends on the first of we or ce rising while both were low
      write_end = ~stb_prev_ff.we_n & ~stb_prev_ff.ce_n & (we_rise | ce_rise);
      read_act  = ~stb.ce_n & ~stb.oe_n & stb.we_n;
   end

   // ---------------------------------------------------------------
   // address latch
   // ---------------------------------------------------------------
   logic [15:0] addr_hold_ff;
   logic [15:0] nxt_addr_hold;
   logic        addr_held_ff;
   logic        nxt_addr_held;
   logic [15:0] cyc_addr;

   always_comb begin
      nxt_addr_hold = addr_hold_ff;
      nxt_addr_held = addr_held_ff;
      if (adv_rise && !addr_held_ff) begin
         nxt_addr_hold = pin.addr;
         nxt_addr_held = 1'b1;
      end
      if (write_end || stb.ce_n) begin
         nxt_addr_held = 1'b0;
      end
      // whichever strobe rises first fixes the address of this cycle
      cyc_addr = addr_held_ff ? addr_hold_ff : pin.addr;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         addr_hold_ff <= 16'h0000;
         addr_held_ff <= 1'b0;
      end else begin
         addr_hold_ff <= nxt_addr_hold;
         addr_held_ff <= nxt_addr_held;
      end
   end

   // ---------------------------------------------------------------
   // partition decode
   // ---------------------------------------------------------------
   logic [2:0] psel_ff;
   logic [2:0] nxt_psel;

   pcc_part_decode u_decode (
      .partition_select_field (psel_ff),
      .plane_partition        (plane_partition),
      .partition_count        (partition_count),
      .dual_work_ok           (dual_work_ok)
   );

   function automatic logic [1:0] part_of(input logic [7:0] map, input logic [1:0] plane);
      part_of = map[{plane, 1'b0} +: 2];
   endfunction

   // ---------------------------------------------------------------
   // command state machine
   // ---------------------------------------------------------------
   pcc_state_t  state_ff;
   pcc_state_t  nxt_state;
   logic [15:0] setup_addr_ff;
   logic [15:0] nxt_setup_addr;
   logic [3:0]  seq_err_ff;
   logic [3:0]  nxt_seq_err;
   logic [1:0]  cmd_part;
   logic [7:0]  wr_cmd;
   logic        cfg_load;

   always_comb begin
      nxt_state      = state_ff;
      nxt_setup_addr = setup_addr_ff;
      cfg_load       = 1'b0;
      nxt_seq_err    = seq_err_ff;
      wr_cmd         = pin.data[7:0];
      cmd_part       = part_of(plane_partition, pin.plane);
      // program supply level is not consulted anywhere on this path
      if (write_end) begin
         case (state_ff)
            ST_CFG_SETUP: begin
               if (wr_cmd == CMD_PART_CONFIRM && cyc_addr == setup_addr_ff) begin
                  cfg_load    = 1'b1;
                  nxt_seq_err = 4'h0;
                  nxt_state   = ST_READ_ARRAY;
               end else begin
                  nxt_seq_err[cmd_part] = 1'b1;
                  nxt_state             = ST_READ_STATUS;
               end
            end
            default: begin
               case (wr_cmd)
                  CMD_CFG_SETUP: begin
                     nxt_setup_addr = cyc_addr;
                     nxt_state      = ST_CFG_SETUP;
                  end
                  CMD_READ_ID: begin
                     nxt_state = ST_READ_ID;
                  end
                  CMD_READ_STATUS: begin
                     nxt_state = ST_READ_STATUS;
                  end
                  CMD_CLEAR_STATUS: begin
                     nxt_seq_err = 4'h0;
                  end
                  CMD_READ_ARRAY: begin
                     nxt_state = ST_READ_ARRAY;
                  end
                  default: begin
                     nxt_state = state_ff;
                  end
               endcase
            end
         endcase
      end
   end

   // reset pin of the device is rst_b; the host keeps it released during a sequence
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff      <= ST_READ_ARRAY;
         setup_addr_ff <= 16'h0000;
         seq_err_ff    <= 4'h0;
      end else begin
         state_ff      <= nxt_state;
         setup_addr_ff <= nxt_setup_addr;
         seq_err_ff    <= nxt_seq_err;
      end
   end

   // ---------------------------------------------------------------
   // partition configuration register
   // ---------------------------------------------------------------
   always_comb begin
      nxt_psel = psel_ff;
      if (cfg_load) begin
         // only the selection field is stored; reserved address bits are dropped
         nxt_psel = cyc_addr[PSEL_MSB:PSEL_LSB];
      end
   end

   // volatile: every reset reloads the variant default
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         psel_ff <= PSEL_RST;
      end else begin
         psel_ff <= nxt_psel;
      end
   end

   // ---------------------------------------------------------------
   // register image and dual work gating
   // ---------------------------------------------------------------
   logic [1:0]  rd_part;
   logic [15:0] status_word;
   logic        rd_err;

   always_comb begin
      partition_layout_config                   = 16'h0000;
      partition_layout_config[PSEL_MSB:PSEL_LSB] = psel_ff;
      rd_part      = part_of(plane_partition, pin.plane);
      read_blocked = 1'b0;
      rd_err       = seq_err_ff[rd_part]; // merged planes share one status
      for (int p = 0; p < NUM_PLANES; p++) begin
         // reads stall only if a busy plane lies in the same partition
         if (plane_busy[p] && part_of(plane_partition, p[1:0]) == rd_part) begin
            read_blocked = 1'b1;
         end
      end
      status_word                = 16'h0000;
      status_word[SR_READY_BIT]  = ~read_blocked;
      status_word[SR_ERR_HI_BIT] = rd_err;
      status_word[SR_ERR_LO_BIT] = rd_err;
   end

   // ---------------------------------------------------------------
   // read data path
   // ---------------------------------------------------------------
   logic [15:0] dq_out_ff;
   logic [15:0] nxt_dq_out;
   logic        dq_oe_b_ff;
   logic        nxt_dq_oe_b;

   always_comb begin
      nxt_dq_oe_b = ~read_act;
      case (state_ff)
         ST_READ_ID: begin
            nxt_dq_out = (pin.addr == ID_ADDR_PART_CFG) ? partition_layout_config : 16'h0000;
         end
         ST_READ_STATUS, ST_CFG_SETUP: begin
            nxt_dq_out = status_word;
         end
         ST_READ_ARRAY: begin
            nxt_dq_out = array_data;
         end
         default: begin
            nxt_dq_out = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dq_out_ff  <= 16'h0000;
         dq_oe_b_ff <= 1'b1;
      end else begin
         dq_out_ff  <= nxt_dq_out;
         dq_oe_b_ff <= nxt_dq_oe_b;
      end
   end

   assign dq_out  = dq_out_ff;
   assign dq_oe_b = dq_oe_b_ff;
endmodule
`default_nettype wire

// *** logic/pcc_part_decode.sv ***
// maps the three-bit partition selection onto per-plane partition numbers
`timescale 1ns/1ns
`default_nettype none
module pcc_part_decode (
   input  wire logic [2:0] partition_select_field,
   output logic      [7:0] plane_partition,
   output logic      [2:0] partition_count,
   output logic            dual_work_ok
);
   import pcc_pkg::*;

   // ---------------------------------------------------------------
   // plane map, packed as {plane3, plane2, plane1, plane0}, two bits each
   // ---------------------------------------------------------------
   always_comb begin
      case (partition_select_field)
         3'h0:    plane_partition = {2'd0, 2'd0, 2'd0, 2'd0};
         3'h1:    plane_partition = {2'd1, 2'd1, 2'd1, 2'd0};
         3'h2:    plane_partition = {2'd1, 2'd1, 2'd0, 2'd0};
         3'h4:    plane_partition = {2'd1, 2'd0, 2'd0, 2'd0};
         3'h3:    plane_partition = {2'd2, 2'd2, 2'd1, 2'd0};
         3'h6:    plane_partition = {2'd2, 2'd1, 2'd0, 2'd0};
         3'h5:    plane_partition = {2'd2, 2'd1, 2'd1, 2'd0};
         3'h7:    plane_partition = {2'd3, 2'd2, 2'd1, 2'd0};
         default: plane_partition = 8'h00;
      endcase
      // highest partition number is on plane 3 in every layout
      partition_count = {1'b0, plane_partition[7:6]} + 3'd1;
      dual_work_ok    = (partition_select_field != 3'h0);
   end
endmodule
`default_nettype wire

// *** logic/pcc_pkg.sv ***
// shared constants and types for the partition configuration command block
`default_nettype none
package pcc_pkg;
   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0]  CMD_CFG_SETUP    = 8'h60;
   localparam logic [7:0]  CMD_PART_CONFIRM = 8'h04;
   localparam logic [7:0]  CMD_READ_ID      = 8'h90;
   localparam logic [7:0]  CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0]  CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0]  CMD_READ_ARRAY   = 8'hFF;
   // ---------------------------------------------------------------
   // identifier space and register layout
   // ---------------------------------------------------------------
   localparam logic [15:0] ID_ADDR_PART_CFG = 16'h0006;
   localparam int          PSEL_LSB         = 8;
   localparam int          PSEL_MSB         = 10;
   localparam logic [2:0]  PSEL_RST_BOTTOM  = 3'h1;
   localparam logic [2:0]  PSEL_RST_TOP     = 3'h4;
   localparam int          SR_READY_BIT     = 7;
   localparam int          SR_ERR_HI_BIT    = 5;
   localparam int          SR_ERR_LO_BIT    = 4;
   localparam int          NUM_PLANES       = 4;
   localparam int          SYNC_STAGES      = 2;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic adv_n;
      logic ce_n;
      logic we_n;
      logic oe_n;
   } pcc_strobes_t;

   typedef struct packed {
      logic [1:0]  plane;
      logic [15:0] addr;
      logic [15:0] data;
   } pcc_bus_t;

   typedef enum logic [3:0] {
      ST_READ_ARRAY  = 4'b0001,
      ST_CFG_SETUP   = 4'b0010,
      ST_READ_ID     = 4'b0100,
      ST_READ_STATUS = 4'b1000
   } pcc_state_t;
endpackage
`default_nettype wire
